// *** common/osc_pkg.sv ***
// constants for the oscillator select control block
package osc_pkg;
	// register byte offsets
	localparam logic [3:0] OSC_CTRL_OFS   = 4'h0;
	localparam logic [3:0] OSC_KEY_OFS    = 4'h4;
	localparam logic [3:0] OSC_PPS_OFS    = 4'h8;
	// field positions in the oscillator control word
	localparam int CUR_SRC_LSB            = 12;
	localparam int NXT_SRC_LSB            = 8;
	localparam int PIN_LOCK_BIT           = 6;
	localparam int PLL_LOCK_BIT           = 5;
	// unlock key words, written in this order
	localparam logic [15:0] UNLOCK_KEY1   = 16'h0046;
	localparam logic [15:0] UNLOCK_KEY2   = 16'h0057;
	// reset values
	localparam logic [2:0] NXT_SRC_RST    = 3'h0;
	localparam logic [15:0] PPS_MAP_RST   = 16'h0000;
	// pll start-up time and its count at 25 MHz
	localparam int PLL_START_NS           = 2000;
	localparam int CLK_PERIOD_NS          = 40;
	localparam int PLL_START_CYC          = (PLL_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		SRC_FAST_RC_OSC      = 3'h0,
		SRC_FAST_RC_OSC_PLL  = 3'h1,
		SRC_PRI              = 3'h2,
		SRC_PRI_PLL          = 3'h3,
		SRC_SEC              = 3'h4,
		SRC_LOW_POWER_RC_OSC = 3'h5,
		SRC_FAST_RC_OSC_D16  = 3'h6,
		SRC_FAST_RC_OSC_DN   = 3'h7
	} osc_src_t;
endpackage : osc_pkg

// *** core/osc_select_control.sv ***
// oscillator control register, clock switch and pin-select lock
//
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
//
// What this block does
// R1: Clock sources use one 3-bit code for both the requested and the current source field.
// R2: The pll lock flag reads 1 only when the pll is in lock and its start-up timer has run out.
// R3: While the pin-select lock bit is set, writes to the pin-select map are ignored.
// R4: While the pin-select lock bit is clear, writes to the pin-select map are taken.
// R5: A direct switch between the two pll sources is refused; software goes through fast rc.
// R6: The control register is cleared only by power-on reset, not by other resets.
// R7: After a reset with a pll source selected the system clock is held until pll lock and until its start-up timer has run out.
// R8: A control write takes effect only right after the two-word unlock sequence.
module osc_select_control
	import osc_pkg::*;
#(
	parameter int PLL_CYC = PLL_START_CYC
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        sysResetReq,
	input  wire logic        pllLockedIn,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	output logic [2:0]       currentSource,
	output logic             sysClockHold,
	output logic [15:0]      pinSelectMap
);
	// timer counter is 16 bits wide
	if (PLL_CYC < 1 || PLL_CYC > 65535) begin : gBadCyc
		$error("PLL_CYC out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	logic rstMeta_r, rstSync_r, lockMeta_r, lockSync_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end
	wire rstn = rstSync_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lockMeta_r <= 1'b0;
			lockSync_r <= 1'b0;
		end else begin
			lockMeta_r <= pllLockedIn;
			lockSync_r <= lockMeta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	function automatic logic isPll(input logic [2:0] s);
		return (s == SRC_FAST_RC_OSC_PLL) || (s == SRC_PRI_PLL);
	endfunction : isPll

	logic [2:0]  nextSrc_r, curSrc_r;
	logic        pinLock_r;
	logic [15:0] ppsMap_r;
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_HALF,
		KEY_OPEN
	} osc_key_t;
	osc_key_t    keyState_r;
	osc_key_t    keyState_nxt;
	logic [15:0] pllCnt_r;
	logic        ack_r;

	wire req       = (read | write) & ~ack_r;
	wire wrCtrl    = write & ~ack_r & (address == OSC_CTRL_OFS);
	wire wrKey     = write & ~ack_r & (address == OSC_KEY_OFS);
	wire wrPps     = write & ~ack_r & (address == OSC_PPS_OFS);
	wire keyOneWr  = wrKey & (writedata[15:0] == UNLOCK_KEY1);
	wire keyTwoWr  = wrKey & (writedata[15:0] == UNLOCK_KEY2);
	wire unlocked  = (keyState_r == KEY_OPEN);
	wire [2:0] wNxt = writedata[NXT_SRC_LSB +: 3];
	// R5: pll to pll switch refused
	wire pllToPll  = isPll(curSrc_r) && isPll(nextSrc_r) && (curSrc_r != nextSrc_r);
	// R2: lock flag from pll and start-up timer
	wire pllReady  = lockSync_r && (pllCnt_r == 16'h0000);
	wire [15:0] ctrlWord = {1'b0, curSrc_r, 1'b0, nextSrc_r, 1'b0, pinLock_r,
		pllReady & isPll(curSrc_r), 5'h00};
	// read mux, key and unmapped offsets read zero
	wire [15:0] rdWord   = (address == OSC_CTRL_OFS) ? ctrlWord :
		(address == OSC_PPS_OFS) ? ppsMap_r : 16'h0000;

	assign waitrequest = ~ack_r & (read | write);
	assign currentSource = curSrc_r;
	// R7: hold system clock until lock and start-up timer run out
	assign sysClockHold = isPll(curSrc_r) && !pllReady;
	assign pinSelectMap = ppsMap_r;

	////////////////////////////////////////////////////////////////////////////
	// R6: power-on reset only; sysResetReq leaves it alone
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nextSrc_r <= NXT_SRC_RST;
			curSrc_r  <= NXT_SRC_RST;
			pinLock_r <= 1'b0;
		end else begin
			// R8: write accepted only when unlocked
			if (wrCtrl && unlocked) begin
				// R1: same code for both fields
				nextSrc_r <= wNxt;
				pinLock_r <= writedata[PIN_LOCK_BIT];
			end
			if (!pllToPll)
				curSrc_r <= nextSrc_r;
		end
	end

	// R8: key sequence tracker, any other write drops it
	always_comb begin
		keyState_nxt = keyState_r;
		if (keyOneWr)
			keyState_nxt = KEY_HALF;
		else if (keyTwoWr && keyState_r == KEY_HALF)
			keyState_nxt = KEY_OPEN;
		else if (write && !ack_r)
			keyState_nxt = KEY_IDLE;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			keyState_r <= KEY_IDLE;
		else
			keyState_r <= keyState_nxt;
	end

	// R3: map writes dropped while locked
	// R4: map writes taken while unlocked
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ppsMap_r <= PPS_MAP_RST;
		else if (sysResetReq)
			ppsMap_r <= PPS_MAP_RST;
		else if (wrPps && !pinLock_r)
			ppsMap_r <= writedata[15:0];
	end

	// R2: start-up timer restarts on any source change or loss of lock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			pllCnt_r <= 16'(PLL_CYC);
		else if (!lockSync_r || curSrc_r != nextSrc_r || sysResetReq)
			pllCnt_r <= 16'(PLL_CYC);
		else if (pllCnt_r != 16'h0000)
			pllCnt_r <= pllCnt_r - 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_r    <= 1'b0;
			readdata <= 32'h0000_0000;
		end else begin
			ack_r <= req;
			if (read && !ack_r)
				readdata <= {16'h0000, rdWord};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// R5: refused switch held
	a_pll_to_pll: assert property (@(posedge clk) disable iff (!rstn) // R5
		pllToPll |=> $stable(curSrc_r)) else $error("pll to pll switch taken");
	// R1: current follows request
	a_cur_follow: assert property (@(posedge clk) disable iff (!rstn) // R1
		!pllToPll |=> curSrc_r == $past(nextSrc_r))
		else $error("current source not updated");
	// R3: locked map kept
	a_pps_locked: assert property (@(posedge clk) disable iff (!rstn) // R3
		(wrPps && pinLock_r && !sysResetReq) |=> $stable(ppsMap_r))
		else $error("map written while locked");
	// R4: open map written
	a_pps_open: assert property (@(posedge clk) disable iff (!rstn) // R4
		(wrPps && !pinLock_r && !sysResetReq) |=> ppsMap_r == $past(writedata[15:0]))
		else $error("map write lost");
	// system reset clears map
	a_pps_clear: assert property (@(posedge clk) disable iff (!rstn)
		sysResetReq |=> ppsMap_r == PPS_MAP_RST) else $error("map kept over system reset");
	// R8: keyless write ignored
	a_ctrl_keyed: assert property (@(posedge clk) disable iff (!rstn) // R8
		(wrCtrl && !unlocked) |=> $stable(nextSrc_r)) else $error("write without unlock");
	// R8: unlock used once
	a_key_once: assert property (@(posedge clk) disable iff (!rstn) // R8
		(wrCtrl && unlocked) |=> !unlocked) else $error("unlock outlived its write");
	// R1: request code stored
	a_ctrl_taken: assert property (@(posedge clk) disable iff (!rstn) // R1
		(wrCtrl && unlocked) |=> nextSrc_r == $past(wNxt)) else $error("next source lost");
	// R2: flag needs lock
	a_lock_flag: assert property (@(posedge clk) disable iff (!rstn) // R2
		!lockSync_r |-> ctrlWord[PLL_LOCK_BIT] == 1'b0) else $error("lock flag while unlocked");
	// R2: read flag low
	a_lock_read: assert property (@(posedge clk) disable iff (!rstn) // R2
		(read && !ack_r && address == OSC_CTRL_OFS && (!lockSync_r || !isPll(curSrc_r)))
		|=> readdata[PLL_LOCK_BIT] == 1'b0)
		else $error("lock flag read without lock");
	// R2: timer restarts
	a_timer_reload: assert property (@(posedge clk) disable iff (!rstn) // R2
		!lockSync_r |=> pllCnt_r == 16'(PLL_CYC))
		else $error("start-up timer not restarted");
	// R7: clock held
	a_clk_hold: assert property (@(posedge clk) disable iff (!rstn) // R7
		(isPll(curSrc_r) && !lockSync_r) |-> sysClockHold) else $error("clock not held");
	// R7: hold only pll
	a_hold_free: assert property (@(posedge clk) disable iff (!rstn) // R7
		!isPll(curSrc_r) |-> !sysClockHold) else $error("clock held off pll");
	// R6: control survives
	a_sys_keep: assert property (@(posedge clk) disable iff (!rstn) // R6
		(sysResetReq && !wrCtrl) |=> $stable(nextSrc_r)) else $error("system reset cleared it");
	// R6: lock bit kept
	a_sys_lock: assert property (@(posedge clk) disable iff (!rstn) // R6
		(sysResetReq && !wrCtrl) |=> $stable(pinLock_r))
		else $error("system reset cleared lock bit");
	// one wait state per request
	a_bus_ack: assert property (@(posedge clk) disable iff (!rstn)
		req |=> !waitrequest) else $error("bus not answered");
	// main scenarios
	c_switch: cover property (@(posedge clk) disable iff (!rstn) wrCtrl && unlocked);
	c_pps_block: cover property (@(posedge clk) disable iff (!rstn) wrPps && pinLock_r);
	c_pll_ready: cover property (@(posedge clk) disable iff (!rstn) $rose(pllReady));
	c_pll_refused: cover property (@(posedge clk) disable iff (!rstn) pllToPll);
	c_sys_reset: cover property (@(posedge clk) disable iff (!rstn) sysResetReq && pinLock_r);
endmodule : osc_select_control

// *** sim/testbench.sv ***
// self-checking bench for the oscillator select control block
`timescale 1ns/1ps
module testbench
	import osc_pkg::*;
;
	logic        clk, resetn, sysResetReq, pllLockedIn, read, write, waitrequest, sysClockHold;
	logic [3:0]  address;
	logic [31:0] writedata, readdata, q;
	logic [2:0]  currentSource;
	logic [15:0] pinSelectMap;
	int          errCount, checked, n;

	osc_select_control #(.PLL_CYC(4)) dut (.clk(clk), .resetn(resetn),
		.sysResetReq(sysResetReq), .pllLockedIn(pllLockedIn), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .currentSource(currentSource),
		.sysClockHold(sysClockHold), .pinSelectMap(pinSelectMap));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errCount++;
		conclude();
	end
	////////////////////////////////////////////////////////////////
	task conclude;
		if (errCount == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// one avalon cycle, held until waitrequest is seen low
	task acc(input logic rd, input logic [3:0] a, input logic [31:0] d);
		read <= rd;
		write <= ~rd;
		address <= a;
		writedata <= d;
		do @(posedge clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask : acc
	task ctl(input logic [15:0] v);
		acc(1'b0, OSC_KEY_OFS, {16'h0, UNLOCK_KEY1});
		acc(1'b0, OSC_KEY_OFS, {16'h0, UNLOCK_KEY2});
		acc(1'b0, OSC_CTRL_OFS, {16'h0, v});
		repeat (2) @(posedge clk);
	endtask : ctl
	function automatic logic [31:0] ctw(logic [2:0] c, logic [2:0] x, logic p, logic k);
		return {16'h0, 1'b0, c, 1'b0, x, 1'b0, p, k, 5'h0};
	endfunction : ctw
	task rdc(input logic [31:0] e);
		acc(1'b1, OSC_CTRL_OFS, 32'h0);
		cmp(q, e);
	endtask : rdc
	////////////////////////////////////////////////////////////////
	task tKeyGuard;
		rdc(32'h0);
		acc(1'b0, OSC_CTRL_OFS, 32'h0200);
		rdc(32'h0);
		acc(1'b0, OSC_KEY_OFS, {16'h0, UNLOCK_KEY1});
		acc(1'b0, OSC_CTRL_OFS, 32'h0200);
		rdc(32'h0);
	endtask : tKeyGuard
	task tCodes;
		for (int c = 0; c < 8; c++) begin
			ctl(16'(c) << NXT_SRC_LSB);
			cmp({29'h0, currentSource}, 32'(c));
			rdc(ctw(3'(c), 3'(c), 1'b0, 1'b0));
		end
	endtask : tCodes
	task tPllPath;
		ctl(16'h0300);
		cmp({31'h0, sysClockHold}, 32'h1);
		ctl(16'h0100);
		cmp({29'h0, currentSource}, 32'h3);
		ctl(16'h0000);
		ctl(16'h0100);
		cmp({29'h0, currentSource}, 32'h1);
		ctl(16'h0300);
		cmp({29'h0, currentSource}, 32'h1);
		ctl(16'h0100);
		rdc(ctw(3'h1, 3'h1, 1'b0, 1'b0));
		pllLockedIn <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (sysClockHold !== 1'b0 && n < 30);
		cmp({31'h0, sysClockHold}, 32'h0);
		rdc(ctw(3'h1, 3'h1, 1'b0, 1'b1));
	endtask : tPllPath
	task tPinLock;
		acc(1'b0, OSC_PPS_OFS, 32'h1234);
		cmp({16'h0, pinSelectMap}, 32'h1234);
		ctl(16'h0140);
		acc(1'b0, OSC_PPS_OFS, 32'hbeef);
		cmp({16'h0, pinSelectMap}, 32'h1234);
		acc(1'b1, OSC_PPS_OFS, 32'h0);
		cmp(q, 32'h1234);
		acc(1'b1, 4'hc, 32'h0);
		cmp(q, 32'h0);
		rdc(ctw(3'h1, 3'h1, 1'b1, 1'b1));
	endtask : tPinLock
	task tSysReset;
		sysResetReq <= 1'b1;
		repeat (2) @(posedge clk);
		sysResetReq <= 1'b0;
		repeat (3) @(posedge clk);
		cmp({29'h0, currentSource}, 32'h1);
		cmp({16'h0, pinSelectMap}, 32'h0);
		acc(1'b1, OSC_CTRL_OFS, 32'h0);
		cmp(q & 32'h7740, ctw(3'h1, 3'h1, 1'b1, 1'b0));
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		cmp({29'h0, currentSource}, 32'h0);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(32'h0);
		cmp({16'h0, pinSelectMap}, 32'h0);
	endtask : tSysReset
	////////////////////////////////////////////////////////////////
	initial begin
		{resetn, sysResetReq, pllLockedIn, read, write} = 5'h0;
		address = 4'h0;
		writedata = 32'h0;
		errCount = 0;
		checked = 0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		tKeyGuard();
		tCodes();
		tPllPath();
		tPinLock();
		tSysReset();
		conclude();
	end
endmodule : testbench
